// ==== prw_pkg.sv ====
// Package for the process regulator: register map, reset values, timing and bus carriers.
// Assumes a 10 MHz system clock and an AXI4-Lite master with 32-bit data.
package prw_pkg;

	// ******************************
	// Timing
	// ******************************
	localparam int CLK_HZ = 10_000_000;
	localparam int PERIOD_MS = 4;
	localparam int PERIOD_CYCLES = CLK_HZ / 1000 * PERIOD_MS;
	localparam int HOLD_UNIT_MS = 100;
	localparam int HOLD_PERIODS_PER_UNIT = HOLD_UNIT_MS / PERIOD_MS;
	localparam int DFILT_UNIT_US = 10_000;
	localparam int PERIOD_US = PERIOD_MS * 1000;
	localparam int ITIME_UNIT_MS = 100;
	localparam int ITIME_DIV = 100 * ITIME_UNIT_MS / PERIOD_MS;

	// ******************************
	// Scales and selections
	// ******************************
	localparam int FULL_PCT = 10000;
	localparam int VOLT_MAX = 1000;
	localparam int CURR_MAX = 2000;
	localparam int PID_CHANNEL_CODE = 23;
	localparam int PRIO_PID_CODE = 7;
	localparam int PRIO_RATED_A = 0;
	localparam int PRIO_RATED_B = 1;

	// ******************************
	// Register word indices (byte address = 4 * index)
	// ******************************
	localparam int R_FUNC_SEL = 0;
	localparam int R_MAIN_CH = 1;
	localparam int R_AUX_CH = 2;
	localparam int R_PRIO = 3;
	localparam int R_SP_MIN1 = 4;
	localparam int R_SP_MAX1 = 5;
	localparam int R_SP_MIN2 = 6;
	localparam int R_SP_MAX2 = 7;
	localparam int R_FB_MIN1 = 8;
	localparam int R_FB_MAX1 = 9;
	localparam int R_FB_MIN2 = 10;
	localparam int R_FB_MAX2 = 11;
	localparam int R_FB_GAIN = 12;
	localparam int R_KP = 13;
	localparam int R_TI = 14;
	localparam int R_KD = 15;
	localparam int R_TF = 16;
	localparam int R_CFG = 17;
	localparam int R_DEADB = 18;
	localparam int R_PRESET = 19;
	localparam int R_HOLD = 20;
	localparam int R_FULLSC = 21;
	localparam int R_ZERO = 22;
	localparam int R_SP_SRC = 23;
	localparam int R_UPPER = 24;
	localparam int R_DIRLOCK = 25;
	localparam int R_MODE = 26;
	localparam int R_SUPER = 27;
	localparam int R_CHMAX = 28;
	localparam int R_KEYPAD_SP = 29;
	localparam int R_STAGE1 = 30;
	localparam int N_STAGES = 7;
	localparam int N_RW = 37;
	localparam int R_STATUS = 37;
	localparam int R_OUT = 38;
	localparam int R_SP_DISP = 39;
	localparam int R_FB_DISP = 40;

	// Field positions
	localparam int CFG_ERR_POL = 0;
	localparam int CFG_OUT_POL = 4;
	localparam int FUNC_LIM_LSB = 12;
	localparam int MODE_SP1_CUR = 0;
	localparam int MODE_SP2_CUR = 1;
	localparam int MODE_FB1_CUR = 2;
	localparam int MODE_FB2_CUR = 3;
	localparam int MODE_FB_SEL = 4;

	// Reset values
	localparam logic [15:0] RST_SP_MAX = 16'h03e8;
	localparam logic [15:0] RST_FB_MAX = 16'h01f4;
	localparam logic [15:0] RST_FB_GAIN = 16'h0064;
	localparam logic [15:0] RST_KP = 16'h00c8;
	localparam logic [15:0] RST_TI = 16'h00c8;
	localparam logic [15:0] RST_TF = 16'h03e8;
	localparam logic [15:0] RST_DEADB = 16'h0032;
	localparam logic [15:0] RST_FULLSC = 16'h0064;
	localparam logic [15:0] RST_UPPER = 16'h1388;
	localparam logic [15:0] RST_CHMAX = 16'h1388;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PRESET = 2'b01,
		ST_REGULATE = 2'b11
	} prw_state_t;

	typedef struct packed {
		logic [15:0] sp_ch1;
		logic [15:0] sp_ch2;
		logic [15:0] fb_ch1;
		logic [15:0] fb_ch2;
	} prw_ain_t;

	typedef struct packed {
		logic awvalid;
		logic [7:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [7:0] araddr;
		logic rready;
	} prw_axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} prw_axil_rsp_t;

endpackage

// ==== prw_regulator.sv ====
// Process PID regulator core with its AXI4-Lite register file.
// Assumes analog inputs already digitised (0.01 V or 0.01 mA) and synchronous to clk_i.
`timescale 1ns/1ps

module prw_regulator import prw_pkg::*; #(
	parameter int PERIOD_CYC = PERIOD_CYCLES
) (
	input wire logic clk_i, // System clock, 10 MHz
	input wire logic rst_i, // Synchronous reset, active high
	input wire prw_axil_req_t axi_req_i, // AXI4-Lite request channels
	output prw_axil_rsp_t axi_rsp_o, // AXI4-Lite response channels
	input wire prw_ain_t ain_i, // Digitised setpoint and feedback inputs
	input wire logic run_i, // External run command
	input wire logic dir_i, // External direction, 1 = reverse
	input wire logic [2:0] stage_i, // Multi-stage setpoint select, 0 = main
	output logic signed [15:0] freq_cmd_o, // Frequency command, 0.01 Hz
	output logic freq_cmd_valid_o, // Frequency command drives the channel
	output logic run_dir_o, // Running direction, 1 = reverse
	output logic sleep_enable_o, // Sleep and wake may operate
	output logic tick_o // One pulse per control period
);

	// ******************************
	// Helpers
	// ******************************
	function automatic logic signed [31:0] uext(input logic [15:0] v);
		uext = $signed({16'h0000, v});
	endfunction

	function automatic logic signed [31:0] sext(input logic [15:0] v);
		sext = $signed({{16{v[15]}}, v});
	endfunction

	function automatic logic signed [31:0] sat(input logic signed [31:0] v, input logic signed [31:0] lo,
		input logic signed [31:0] hi);
		if (v < lo) begin
			sat = lo;
		end else if (v > hi) begin
			sat = hi;
		end else begin
			sat = v;
		end
	endfunction

	function automatic logic signed [31:0] absv(input logic signed [31:0] v);
		absv = (v < 0) ? -v : v;
	endfunction

	// Linear map of an analog reading onto 0..FULL_PCT; the top is capped by the input type
	function automatic logic signed [31:0] map_pct(input logic [15:0] x, input logic [15:0] mn,
		input logic [15:0] mx, input logic cur);
		logic signed [31:0] top;
		logic signed [31:0] lo;
		logic signed [31:0] xv;
		top = sat(uext(mx), 0, cur ? CURR_MAX : VOLT_MAX);
		lo = uext(mn);
		xv = uext(x);
		if (top <= lo || xv <= lo) begin
			map_pct = 0;
		end else if (xv >= top) begin
			map_pct = FULL_PCT;
		end else begin
			map_pct = (xv - lo) * FULL_PCT / (top - lo);
		end
	endfunction

	// ******************************
	// Register file
	// ******************************
	logic [15:0] cfg [0:N_RW-1];
	logic aw_got;
	logic w_got;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic [5:0] wr_idx;
	logic wr_fire;
	logic bvalid;
	logic [1:0] bresp;
	logic rvalid;
	logic [31:0] rdata;
	logic [1:0] rresp;

	// Regulator state used by reads
	prw_state_t state;
	logic signed [31:0] u_out;
	logic signed [31:0] sp_disp;
	logic signed [31:0] fb_disp;
	logic in_band;
	logic drive_active;
	logic sleep_ok;

	function automatic logic [15:0] rst_val(input int idx);
		case (idx)
			R_SP_MAX1, R_SP_MAX2: rst_val = RST_SP_MAX;
			R_FB_MAX1, R_FB_MAX2: rst_val = RST_FB_MAX;
			R_FB_GAIN: rst_val = RST_FB_GAIN;
			R_KP: rst_val = RST_KP;
			R_TI: rst_val = RST_TI;
			R_TF: rst_val = RST_TF;
			R_DEADB: rst_val = RST_DEADB;
			R_FULLSC: rst_val = RST_FULLSC;
			R_UPPER: rst_val = RST_UPPER;
			R_CHMAX: rst_val = RST_CHMAX;
			default: rst_val = 16'h0000;
		endcase
	endfunction

	assign wr_idx = aw_addr[7:2];
	assign wr_fire = aw_got && w_got && !bvalid;

	assign axi_rsp_o.awready = !aw_got && !bvalid;
	assign axi_rsp_o.wready = !w_got && !bvalid;
	assign axi_rsp_o.bvalid = bvalid;
	assign axi_rsp_o.bresp = bresp;
	assign axi_rsp_o.arready = !rvalid;
	assign axi_rsp_o.rvalid = rvalid;
	assign axi_rsp_o.rdata = rdata;
	assign axi_rsp_o.rresp = rresp;

	// Address and data are latched independently so either may come first
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (axi_req_i.awvalid && !aw_got && !bvalid) begin
				aw_got <= 1'b1;
				aw_addr <= axi_req_i.awaddr;
			end else if (wr_fire) begin
				aw_got <= 1'b0;
			end
			if (axi_req_i.wvalid && !w_got && !bvalid) begin
				w_got <= 1'b1;
				w_data <= axi_req_i.wdata;
				w_strb <= axi_req_i.wstrb;
			end else if (wr_fire) begin
				w_got <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bvalid <= 1'b0;
			bresp <= 2'b00;
		end else if (wr_fire) begin
			bvalid <= 1'b1;
			bresp <= (int'(wr_idx) < N_RW) ? 2'b00 : 2'b10;
		end else if (bvalid && axi_req_i.bready) begin
			bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < N_RW; i++) begin
				cfg[i] <= rst_val(i);
			end
		end else if (wr_fire && int'(wr_idx) < N_RW) begin
			if (w_strb[0]) begin
				cfg[wr_idx][7:0] <= w_data[7:0];
			end
			if (w_strb[1]) begin
				cfg[wr_idx][15:8] <= w_data[15:8];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= 2'b00;
		end else if (axi_req_i.arvalid && !rvalid) begin
			rvalid <= 1'b1;
			rresp <= 2'b00;
			if (int'(axi_req_i.araddr[7:2]) < N_RW) begin
				rdata <= {16'h0000, cfg[axi_req_i.araddr[7:2]]};
			end else begin
				case (int'(axi_req_i.araddr[7:2]))
					R_STATUS: rdata <= {26'h0, in_band, run_dir_o, sleep_ok, drive_active, state};
					R_OUT: rdata <= u_out;
					R_SP_DISP: rdata <= sp_disp;
					R_FB_DISP: rdata <= fb_disp;
					default: begin
						rdata <= 32'h0000_0000;
						rresp <= 2'b10;
					end
				endcase
			end
		end else if (rvalid && axi_req_i.rready) begin
			rvalid <= 1'b0;
		end
	end

	// ******************************
	// Control period
	// ******************************
	logic [31:0] per_cnt;
	logic tick;

	assign tick = (per_cnt == 32'(PERIOD_CYC - 1));

	always_ff @(posedge clk_i) begin
		if (rst_i || tick) begin
			per_cnt <= 32'h0000_0000;
		end else begin
			per_cnt <= per_cnt + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tick_o <= 1'b0;
		end else begin
			tick_o <= tick;
		end
	end

	// ******************************
	// Mode decode
	// ******************************
	logic [3:0] lim_sel;
	logic dual_pol;

	assign lim_sel = cfg[R_FUNC_SEL][FUNC_LIM_LSB +: 4];
	assign dual_pol = cfg[R_CFG][CFG_OUT_POL];
	assign drive_active = (uext(cfg[R_MAIN_CH]) == PID_CHANNEL_CODE || uext(cfg[R_AUX_CH]) == PID_CHANNEL_CODE)
		&& uext(cfg[R_PRIO]) == PRIO_PID_CODE;
	assign sleep_ok = !drive_active
		&& (uext(cfg[R_PRIO]) == PRIO_RATED_A || uext(cfg[R_PRIO]) == PRIO_RATED_B);

	// ******************************
	// Setpoint, feedback and error
	// ******************************
	logic signed [31:0] sp_main;
	logic signed [31:0] sp_pct;
	logic signed [31:0] fb_raw;
	logic signed [31:0] fb_pct;
	logic signed [31:0] err;
	logic signed [31:0] band;

	always_comb begin
		case (cfg[R_SP_SRC][1:0])
			2'b00: sp_main = map_pct(ain_i.sp_ch1, cfg[R_SP_MIN1], cfg[R_SP_MAX1], cfg[R_MODE][MODE_SP1_CUR]);
			2'b01: sp_main = map_pct(ain_i.sp_ch2, cfg[R_SP_MIN2], cfg[R_SP_MAX2], cfg[R_MODE][MODE_SP2_CUR]);
			default: sp_main = sat(uext(cfg[R_KEYPAD_SP]), 0, FULL_PCT);
		endcase
		if (stage_i != 3'h0) begin
			sp_pct = sp_main * uext(cfg[R_STAGE1 + int'(stage_i) - 1]) / 1000;
		end else begin
			sp_pct = sp_main;
		end
		if (cfg[R_MODE][MODE_FB_SEL]) begin
			fb_raw = map_pct(ain_i.fb_ch2, cfg[R_FB_MIN2], cfg[R_FB_MAX2], cfg[R_MODE][MODE_FB2_CUR]);
		end else begin
			fb_raw = map_pct(ain_i.fb_ch1, cfg[R_FB_MIN1], cfg[R_FB_MAX1], cfg[R_MODE][MODE_FB1_CUR]);
		end
		fb_pct = fb_raw * uext(cfg[R_FB_GAIN]) / 100;
		err = cfg[R_CFG][CFG_ERR_POL] ? fb_pct - sp_pct : sp_pct - fb_pct;
		band = uext(cfg[R_DEADB]) * 10;
	end

	assign in_band = absv(err) <= band;

	// ******************************
	// PID terms
	// ******************************
	logic signed [47:0] i_acc;
	logic signed [31:0] err_prev;
	logic signed [31:0] d_filt;
	logic signed [31:0] p_term;
	logic signed [31:0] i_term;
	logic signed [31:0] d_raw;
	logic signed [31:0] d_step;
	logic signed [47:0] next_i_acc;
	logic signed [47:0] i_lim;
	logic signed [31:0] preset_pct;
	logic signed [31:0] next_u;

	assign i_lim = 48'(FULL_PCT) * 48'(ITIME_DIV);
	assign preset_pct = uext(cfg[R_PRESET]) * 10;

	always_comb begin
		p_term = uext(cfg[R_KP]) * err / 100;
		next_i_acc = i_acc;
		if (cfg[R_TI] != 16'h0000) begin
			next_i_acc = i_acc + 48'(uext(cfg[R_KP]) * err / uext(cfg[R_TI]));
		end
		if (next_i_acc > i_lim) begin
			next_i_acc = i_lim;
		end else if (next_i_acc < -i_lim) begin
			next_i_acc = -i_lim;
		end
		i_term = 32'(i_acc / 48'(ITIME_DIV));
		d_raw = uext(cfg[R_KD]) * (err - err_prev) / 100;
		// Filter step T/(Tf+T) keeps the smoothing exact at the 4 ms period
		d_step = (d_raw - d_filt) * PERIOD_US / (uext(cfg[R_TF]) * DFILT_UNIT_US + PERIOD_US);
		next_u = p_term + i_term + d_filt;
		if (dual_pol) begin
			next_u = sat(next_u, -FULL_PCT, FULL_PCT);
		end else begin
			next_u = sat(next_u, 0, FULL_PCT);
		end
	end

	// ******************************
	// Start sequence
	// ******************************
	logic [31:0] hold_cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			state <= ST_IDLE;
			hold_cnt <= 32'h0000_0000;
		end else if (tick) begin
			case (state)
				ST_IDLE: begin
					state <= ST_PRESET;
					hold_cnt <= 32'(uext(cfg[R_HOLD]) * HOLD_PERIODS_PER_UNIT);
				end
				ST_PRESET: begin
					if (hold_cnt == 32'h0000_0000) begin
						state <= ST_REGULATE;
					end else begin
						hold_cnt <= hold_cnt - 32'h0000_0001;
					end
				end
				ST_REGULATE: state <= ST_REGULATE;
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Integrator starts from the preset so the hand-over to closed loop is bumpless
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			i_acc <= 48'sh0;
			err_prev <= 32'sh0;
			d_filt <= 32'sh0;
			u_out <= 32'sh0;
		end else if (tick) begin
			err_prev <= err;
			case (state)
				ST_REGULATE: begin
					if (!in_band) begin
						i_acc <= next_i_acc;
						u_out <= next_u;
					end
					d_filt <= (cfg[R_KD] == 16'h0000) ? 32'sh0 : d_filt + d_step;
				end
				ST_PRESET: begin
					i_acc <= 48'(preset_pct) * 48'(ITIME_DIV);
					d_filt <= 32'sh0;
					u_out <= preset_pct;
				end
				default: begin
					i_acc <= 48'sh0;
					d_filt <= 32'sh0;
					u_out <= 32'sh0;
				end
			endcase
		end
	end

	// ******************************
	// Frequency command and direction
	// ******************************
	logic signed [31:0] u_eff;
	logic signed [31:0] f_cmd;
	logic signed [31:0] f_lim;
	logic signed [31:0] sup;
	logic signed [31:0] upper;
	logic lock;

	assign lock = cfg[R_DIRLOCK][0];
	assign sup = sext(cfg[R_SUPER]);
	assign upper = uext(cfg[R_UPPER]);

	always_comb begin
		u_eff = (dual_pol && lock) ? absv(u_out) : u_out;
		f_cmd = u_eff * upper / FULL_PCT;
		case (lim_sel)
			4'h0: f_lim = uext(cfg[R_CHMAX]);
			4'h1: f_lim = absv(sup);
			4'h2: f_lim = ((u_eff < 0) == (sup < 0)) ? upper - absv(sup) : absv(sup);
			default: f_lim = uext(cfg[R_CHMAX]);
		endcase
		f_lim = sat(f_lim, 0, upper);
		f_cmd = sat(f_cmd, -f_lim, f_lim);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			freq_cmd_o <= 16'sh0000;
			freq_cmd_valid_o <= 1'b0;
			run_dir_o <= 1'b0;
			sleep_enable_o <= 1'b0;
		end else begin
			// Gate on state too, so a stop clears the command without waiting for a period
			freq_cmd_o <= (drive_active && state != ST_IDLE) ? f_cmd[15:0] : 16'sh0000;
			freq_cmd_valid_o <= drive_active && state != ST_IDLE;
			sleep_enable_o <= sleep_ok;
			if (dual_pol && !lock) begin
				run_dir_o <= dir_i ^ u_eff[31];
			end else begin
				run_dir_o <= dir_i;
			end
		end
	end

	// ******************************
	// Display values
	// ******************************
	// Both readings share the zero and full-scale sensor mapping
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sp_disp <= 32'sh0;
			fb_disp <= 32'sh0;
		end else if (tick) begin
			sp_disp <= sext(cfg[R_ZERO]) + sp_pct * (uext(cfg[R_FULLSC]) - sext(cfg[R_ZERO])) / FULL_PCT;
			fb_disp <= sext(cfg[R_ZERO]) + fb_pct * (uext(cfg[R_FULLSC]) - sext(cfg[R_ZERO])) / FULL_PCT;
		end
	end

endmodule

// ==== prw_regulator_sva.sv ====
// Checker for prw_regulator: bus handshakes, control period and stop behaviour.
// Sees only the top ports and is bound from the foot of this file.
`timescale 1ns/1ps
module prw_regulator_sva import prw_pkg::*; #(
	parameter int PERIOD_CYC = PERIOD_CYCLES
) (
	input wire logic clk_i, // Clock
	input wire logic rst_i, // Reset
	input wire prw_axil_req_t axi_req_i, // Bus requests
	input wire prw_axil_rsp_t axi_rsp_o, // Bus answers
	input wire logic run_i, // Run command
	input wire logic signed [15:0] freq_cmd_o, // Command
	input wire logic freq_cmd_valid_o, // Command drives
	input wire logic tick_o // Period pulse
);
	// ****************
	// Period counter
	// ****************
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	int cnt;
	logic seen;
	always_ff @(posedge clk_i) begin
		cnt <= (rst_i || tick_o) ? 0 : cnt + 1;
	end
	// The first period after reset is longer by the pipeline, so it is skipped
	always_ff @(posedge clk_i) begin
		seen <= rst_i ? 1'b0 : (seen || tick_o);
	end
	// ****************
	// Properties
	// ****************
	property p_period; tick_o && seen |-> cnt == PERIOD_CYC - 1; endproperty
	a_period: assert property (p_period) else $error("control period length wrong");
	property p_pulse; tick_o |=> !tick_o; endproperty
	a_pulse: assert property (p_pulse) else $error("period pulse too long");
	property p_idle_zero; tick_o && !freq_cmd_valid_o |-> freq_cmd_o == 0; endproperty
	a_idle_zero: assert property (p_idle_zero) else $error("command not zero while not driving");
	property p_run_low; tick_o && !$past(run_i, 2) |-> freq_cmd_o == 0 && !freq_cmd_valid_o; endproperty
	a_run_low: assert property (p_run_low) else $error("command kept after stop");
	property p_b_hold; axi_rsp_o.bvalid && !axi_req_i.bready |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold; axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	sequence s_wtake;
		axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready;
	endsequence
	property p_w_answer; s_wtake |-> ##2 axi_rsp_o.bvalid; endproperty
	a_w_answer: assert property (p_w_answer) else $error("write answer late");
	property p_bad_write; s_wtake ##0 axi_req_i.awaddr >= 8'h94 |-> ##2 axi_rsp_o.bresp == 2'b10; endproperty
	a_bad_write: assert property (p_bad_write) else $error("read-only write not refused");
	property p_bad_read; axi_req_i.arvalid && axi_rsp_o.arready && axi_req_i.araddr > 8'ha3
		|=> axi_rsp_o.rvalid && axi_rsp_o.rresp == 2'b10 && axi_rsp_o.rdata == 0; endproperty
	a_bad_read: assert property (p_bad_read) else $error("unmapped read not refused");
	c_drive: cover property (tick_o && freq_cmd_valid_o);
	c_refused: cover property (axi_rsp_o.bvalid && axi_rsp_o.bresp == 2'b10);
	c_reverse: cover property (freq_cmd_o < 0);
endmodule
bind prw_regulator prw_regulator_sva #(.PERIOD_CYC(PERIOD_CYC)) u_sva (.clk_i(clk_i), .rst_i(rst_i),
	.axi_req_i(axi_req_i), .axi_rsp_o(axi_rsp_o), .run_i(run_i), .freq_cmd_o(freq_cmd_o),
	.freq_cmd_valid_o(freq_cmd_valid_o), .tick_o(tick_o));

// ==== prw_sensor_model.sv ====
// Process sensor model: digitised setpoint and feedback levels on channel 1.
// Assumes the bench sets the levels; channel 2 is left unwired.
`timescale 1ns/1ps
module prw_sensor_model import prw_pkg::*; (
	input wire logic clk_i, // Clock
	input wire logic [15:0] sp_i, // Setpoint level
	input wire logic [15:0] fb_i, // Feedback level
	input wire logic slow_i, // Slow settling
	output prw_ain_t ain_o // Digitised inputs
);
	logic [3:0] age;
	logic [15:0] wobble;
	initial begin
		ain_o = '0;
		age = 4'h0;
		wobble = 16'h5a5a;
	end
	// Unwired inputs float, so they never show a steady value
	always @(posedge clk_i) begin
		wobble <= ~wobble;
		ain_o.sp_ch2 <= wobble;
		ain_o.fb_ch2 <= ~wobble;
		age <= (ain_o.sp_ch1 != sp_i || ain_o.fb_ch1 != fb_i) ? age + 4'h1 : 4'h0;
		if (!slow_i || age == 4'h7) begin
			ain_o.sp_ch1 <= sp_i;
			ain_o.fb_ch1 <= fb_i;
		end
	end
endmodule

// ==== test_process_pid_regulator.sv ====
// Testbench for prw_regulator: registers, drive selection, preset, limits and PID paths.
// Assumes a short control period set by parameter.
`timescale 1ns/1ps
module test_process_pid_regulator import prw_pkg::*;;
	localparam int PC = 40;
	logic clk_i, rst_i, run_i, dir_i, slow, fvalid, rdir, sleep, tick;
	logic [2:0] stage_i;
	logic [15:0] sp_lvl, fb_lvl;
	prw_axil_req_t req;
	prw_axil_rsp_t rsp;
	prw_ain_t ain;
	logic signed [15:0] freq;
	int num_errors, n_checks;
	logic [31:0] rv;
	logic [1:0] rr;
	prw_regulator #(.PERIOD_CYC(PC)) DUT (.clk_i(clk_i), .rst_i(rst_i), .axi_req_i(req), .axi_rsp_o(rsp),
		.ain_i(ain), .run_i(run_i), .dir_i(dir_i), .stage_i(stage_i), .freq_cmd_o(freq),
		.freq_cmd_valid_o(fvalid), .run_dir_o(rdir), .sleep_enable_o(sleep), .tick_o(tick));
	prw_sensor_model u_sens (.clk_i(clk_i), .sp_i(sp_lvl), .fb_i(fb_lvl), .slow_i(slow), .ain_o(ain));
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end
	// ****************
	// Shared tasks
	// ****************
	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic complete_run();
		if (num_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic give_up();
		num_errors++;
		complete_run();
	endtask
	task automatic wr(input int idx, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		req.awaddr <= 8'(idx * 4);
		req.wdata <= d;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_i);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				rr = rsp.bresp;
				req.bready <= 1'b0;
				return;
			end
		end
		give_up();
	endtask
	task automatic rd(input int idx);
		int n;
		@(posedge clk_i);
		req.araddr <= 8'(idx * 4);
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_i);
			if (rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				rv = rsp.rdata;
				rr = rsp.rresp;
				req.rready <= 1'b0;
				return;
			end
		end
		give_up();
	endtask
	task automatic ticks(input int k);
		int n, seen;
		seen = 0;
		for (n = 0; n < (k + 1) * PC && seen < k; n++) begin
			@(posedge clk_i);
			if (tick) seen++;
		end
		if (seen < k) give_up();
	endtask
	task automatic do_reset();
		rst_i <= 1'b1;
		run_i <= 1'b0;
		stage_i <= 3'h0;
		slow <= 1'b0;
		sp_lvl <= 16'h0258;
		fb_lvl <= 16'h00fa;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
	endtask
	// Setpoint 60 %, feedback 50 %, proportional gain 1.00, no integral
	task automatic pid_setup(input logic [15:0] cfg);
		do_reset();
		wr(R_MAIN_CH, 32'h17);
		wr(R_PRIO, 32'h7);
		wr(R_TI, 32'h0);
		wr(R_KP, 32'h64);
		wr(R_CFG, 32'(cfg));
		run_i <= 1'b1;
		ticks(4);
	endtask
	// ****************
	// Scenarios
	// ****************
	task automatic t_regs();
		logic [15:0] e;
		int i;
		do_reset();
		for (i = 0; i < N_RW; i++) begin
			case (i)
				R_SP_MAX1, R_SP_MAX2, R_TF: e = 16'h03e8;
				R_FB_GAIN, R_FULLSC: e = 16'h0064;
				R_KP, R_TI: e = 16'h00c8;
				R_FB_MAX1, R_FB_MAX2: e = 16'h01f4;
				R_DEADB: e = 16'h0032;
				R_UPPER, R_CHMAX: e = RST_UPPER;
				default: e = 16'h0000;
			endcase
			rd(i);
			check("reset value", rv, {16'h0000, e});
		end
		rd(41);
		check("unmapped rresp", 32'(rr), 32'h2);
		check("unmapped rdata", rv, 32'h0);
		wr(R_STATUS, 32'h3);
		check("read-only bresp", 32'(rr), 32'h2);
		rd(R_STATUS);
		check("read-only kept", rv, 32'h18);
		wr(R_KP, 32'habcd_1234);
		rd(R_KP);
		check("low half stored", rv, 32'h0000_1234);
	endtask
	task automatic t_drive();
		logic [7:0] mc[6] = '{8'h17, 8'h17, 8'h00, 8'h00, 8'h17, 8'h17};
		logic [7:0] ac[6] = '{8'h00, 8'h00, 8'h00, 8'h17, 8'h00, 8'h00};
		logic [3:0] pr[6] = '{4'h7, 4'h6, 4'h7, 4'h7, 4'h0, 4'h1};
		logic [5:0] ev = 6'b001001;
		logic [5:0] es = 6'b110000;
		int i;
		do_reset();
		wr(R_PRESET, 32'h1f4);
		wr(R_HOLD, 32'h14);
		run_i <= 1'b1;
		for (i = 0; i < 6; i++) begin
			wr(R_MAIN_CH, 32'(mc[i]));
			wr(R_AUX_CH, 32'(ac[i]));
			wr(R_PRIO, 32'(pr[i]));
			ticks(3);
			check("drive valid", 32'(fvalid), 32'(ev[i]));
			check("drive command", 32'(freq), ev[i] ? 32'h9c4 : 32'h0);
			check("sleep permit", 32'(sleep), 32'(es[i]));
		end
	endtask
	task automatic t_preset();
		logic [15:0] fs[3] = '{16'h0000, 16'h1000, 16'h2000};
		logic [15:0] sv[3] = '{16'h0000, 16'h07d0, 16'h03e8};
		logic [31:0] ef[3] = '{32'hbb8, 32'h7d0, 32'hfa0};
		int i;
		do_reset();
		wr(R_MAIN_CH, 32'h17);
		wr(R_PRIO, 32'h7);
		wr(R_PRESET, 32'h3e8);
		wr(R_HOLD, 32'h14);
		wr(R_CHMAX, 32'hbb8);
		run_i <= 1'b1;
		ticks(3);
		rd(R_OUT);
		check("preset output", rv, 32'h2710);
		for (i = 0; i < 3; i++) begin
			wr(R_FUNC_SEL, 32'(fs[i]));
			wr(R_SUPER, 32'(sv[i]));
			ticks(2);
			check("limited command", 32'(freq), ef[i]);
		end
		run_i <= 1'b0;
		ticks(2);
		check("stopped command", 32'(freq), 32'h0);
		check("stopped valid", 32'(fvalid), 32'h0);
	endtask
	task automatic t_hold();
		do_reset();
		wr(R_HOLD, 32'h1);
		run_i <= 1'b1;
		ticks(24);
		rd(R_STATUS);
		check("hold running", 32'(rv[1:0]), 32'(ST_PRESET));
		ticks(5);
		rd(R_STATUS);
		check("hold over", 32'(rv[1:0]), 32'(ST_REGULATE));
		run_i <= 1'b0;
		ticks(2);
		rd(R_STATUS);
		check("stopped", 32'(rv[1:0]), 32'(ST_IDLE));
	endtask
	task automatic t_polarity();
		logic [15:0] cfg[4] = '{16'h0000, 16'h0001, 16'h0011, 16'h0011};
		logic [31:0] ef[4] = '{32'h1f4, 32'h0, 32'hffff_fe0c, 32'h1f4};
		logic [3:0] ed = 4'b1011;
		int i;
		for (i = 0; i < 4; i++) begin
			pid_setup(cfg[i]);
			wr(R_DIRLOCK, 32'(i / 3));
			ticks(2);
			check("frequency command", 32'(freq), ef[i]);
			check("running direction", 32'(rdir), 32'(ed[i]));
		end
	endtask
	task automatic t_band();
		pid_setup(16'h0000);
		fb_lvl <= 16'h0113;
		ticks(3);
		check("held in band", 32'(freq), 32'h1f4);
		slow <= 1'b1;
		wr(R_FB_GAIN, 32'hc8);
		fb_lvl <= 16'h0064;
		ticks(3);
		check("gain applied", 32'(freq), 32'h3e8);
		wr(R_STAGE1, 32'h1f4);
		stage_i <= 3'h1;
		fb_lvl <= 16'h0032;
		ticks(3);
		check("stage setpoint", 32'(freq), 32'h1f4);
		rd(R_FB_DISP);
		check("feedback display", rv, 32'h14);
		rd(R_SP_DISP);
		check("setpoint display", rv, 32'h1e);
	endtask
	task automatic t_integral();
		logic [31:0] e;
		pid_setup(16'h0000);
		// Error steps from 10 % to 20 %; the filtered kick shows one period later
		wr(R_KD, 32'h64);
		wr(R_TF, 32'h1);
		ticks(1);
		fb_lvl <= 16'h00c8;
		ticks(2);
		rd(R_OUT);
		check("filtered derivative", rv, 32'h8ed);
		wr(R_KD, 32'h0);
		wr(R_TI, 32'ha);
		ticks(2);
		rd(R_OUT);
		e = rv;
		ticks(5);
		rd(R_OUT);
		check("integral rises", 32'(rv > e), 32'h1);
	endtask
	initial begin
		rst_i = 1'b1;
		run_i = 1'b0;
		dir_i = 1'b1;
		stage_i = 3'h0;
		slow = 1'b0;
		sp_lvl = 16'h0258;
		fb_lvl = 16'h00fa;
		req = '0;
		req.wstrb = 4'hf;
		num_errors = 0;
		n_checks = 0;
		t_regs();
		t_drive();
		t_preset();
		t_hold();
		t_polarity();
		t_band();
		t_integral();
		complete_run();
	end
endmodule
